// ### rtl/ads_seq_status.sv
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "ads_defines.svh"

module ads_seq_status
(
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`ADS_ADDR_W-1:0]   paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  ads_pkg::ads_ev_s              ev,
	output ads_pkg::ads_ctrl_s            seq_ctrl,
	output ads_pkg::ads_idx_t             conversion_index,
	output logic                          sequence_done_flag,
	output logic                          trigger_overrun_flag,
	output logic                          result_overrun_flag,
	output logic                          seq_running,
	output logic                          seq_start,
	output logic                          seq_abort,
	output logic                          irq
);
	import ads_pkg::*;

	// ---------------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------------
	wire        acc;
	wire        setup_rd;
	wire        wr;
	wire        hit_ctrl;
	wire        hit_start;
	wire        hit_ist;
	wire        hit_iclr;
	wire        hit_ien;
	wire        hit_status;
	wire        mapped;
	wire        wr_ctrl;
	wire        start_wr;
	wire        wr_iclr;
	wire        wr_ien;
	wire        wr_status;
	logic [31:0] rd_val;
	logic [31:0] prdata_q;

	assign acc        = psel & penable;
	assign setup_rd   = psel & ~penable & ~pwrite;
	assign wr         = acc & pwrite;
	assign hit_ctrl   = paddr == `ADS_OFF_CTRL;
	assign hit_start  = paddr == `ADS_OFF_START;
	assign hit_ist    = paddr == `ADS_OFF_INT_STATUS;
	assign hit_iclr   = paddr == `ADS_OFF_INT_CLEAR;
	assign hit_ien    = paddr == `ADS_OFF_INT_ENABLE;
	assign hit_status = paddr == 8'(`ADS_OFF_STATUS);
	assign mapped     = hit_ctrl | hit_start | hit_ist | hit_iclr | hit_ien
	                    | hit_status;
	assign wr_ctrl    = wr & hit_ctrl;
	assign start_wr   = wr & hit_start;
	assign wr_iclr    = wr & hit_iclr;
	assign wr_ien     = wr & hit_ien;
	assign wr_status  = wr & hit_status;

	// zero wait states; read data is captured in the setup cycle
	assign pready  = acc;
	assign pslverr = acc & ~mapped;

	// ---------------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------------
	logic [4:0] ctrl_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_q <= `ADS_CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= pwdata[4:0];
	end

	assign seq_ctrl.ext_trig_en          = ctrl_q[`ADS_CTRL_ETE];
	assign seq_ctrl.trigger_level_select = ctrl_q[`ADS_CTRL_TLS];
	assign seq_ctrl.scan_mode            = ctrl_q[`ADS_CTRL_SCAN];
	assign seq_ctrl.fast_flag_clear      = ctrl_q[`ADS_CTRL_FFC];
	assign seq_ctrl.fifo_mode            = ctrl_q[`ADS_CTRL_FIFO];

	// ---------------------------------------------------------------------
	// sequence run state
	// ---------------------------------------------------------------------
	ads_run_e state_q;
	ads_run_e state_d;
	logic     armed_q;
	wire      run;
	wire      trig_start;
	wire      aborting;
	wire      seq_end;
	wire      cont;

	assign run        = state_q == ADS_RUN;
	// with an external trigger a start write arms, each edge while not running then starts
	assign trig_start = ~run & armed_q & seq_ctrl.ext_trig_en & ev.trig_edge;
	assign aborting   = ev.ctl_abort_wr | (start_wr & run);
	// external trigger always runs one sequence, scan has no effect there
	assign cont       = seq_ctrl.scan_mode & ~seq_ctrl.ext_trig_en;
	assign seq_end    = run & ev.seq_done & ~cont;

	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ADS_IDLE:
				if (start_wr | trig_start)
					state_d = ADS_RUN;
			ADS_RUN:
				if (start_wr)
					state_d = ADS_RUN;
				else if (ev.ctl_abort_wr | seq_end)
					state_d = ADS_IDLE;
			default:
				state_d = ADS_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q   <= ADS_IDLE;
			armed_q   <= 1'b0;
			seq_start <= 1'b0;
			seq_abort <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			armed_q   <= start_wr | (armed_q & ~ev.ctl_abort_wr);
			seq_start <= start_wr | trig_start;
			seq_abort <= aborting;
		end
	end

	assign seq_running = run;

	// ---------------------------------------------------------------------
	// status flags, a set always beats a clear in the same cycle
	// ---------------------------------------------------------------------
	logic sdf_q;
	logic tof_q;
	logic rof_q;
	wire  sdf_set;
	wire  tof_set;
	wire  rof_set;
	wire  sdf_clr;
	wire  tof_clr;
	wire  rof_clr;

	assign sdf_set = ev.seq_done;
	assign tof_set = ev.trig_edge & run & seq_ctrl.ext_trig_en
	                 & ~seq_ctrl.trigger_level_select;
	assign rof_set = ev.result_wr & ev.conv_flag_set;

	assign sdf_clr = (wr_status & pwdata[`ADS_BIT_SDF]) | start_wr
	                 | (seq_ctrl.fast_flag_clear & ev.result_rd);
	assign tof_clr = (wr_status & pwdata[`ADS_BIT_TOF]) | start_wr
	                 | ev.ctl_abort_wr;
	assign rof_clr = (wr_status & pwdata[`ADS_BIT_ROF]) | start_wr
	                 | ev.ctl_abort_wr;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sdf_q <= 1'b0;
			tof_q <= 1'b0;
			rof_q <= 1'b0;
		end
		else
		begin
			sdf_q <= sdf_set | (sdf_q & ~sdf_clr);
			tof_q <= tof_set | (tof_q & ~tof_clr);
			rof_q <= rof_set | (rof_q & ~rof_clr);
		end
	end

	assign sequence_done_flag   = sdf_q;
	assign trigger_overrun_flag = tof_q;
	assign result_overrun_flag  = rof_q;

	// ---------------------------------------------------------------------
	// conversion index and interrupts
	// ---------------------------------------------------------------------
	ads_int_t int_status;
	ads_int_t int_enable;

	ads_conv_cnt u_cnt
	(
		.clk              (clk),
		.rst              (rst),
		.restart          (start_wr | aborting),
		.seq_bound        (trig_start | ev.seq_done),
		.conv_done        (ev.conv_done),
		.fifo_mode        (seq_ctrl.fifo_mode),
		.conversion_index (conversion_index)
	);

	ads_irq u_irq
	(
		.clk        (clk),
		.rst        (rst),
		.set        ({rof_set, tof_set, sdf_set}),
		.clr_wr     (wr_iclr),
		.en_wr      (wr_ien),
		.wdata      (pwdata[`ADS_INT_W-1:0]),
		.int_status (int_status),
		.int_enable (int_enable),
		.irq        (irq)
	);

	// ---------------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------------
	wire [7:0] status_val;

	// unused bit 6 is hard zero
	assign status_val =
		{sdf_q, 1'b0, tof_q, rof_q, conversion_index};

	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (hit_ctrl)
			rd_val = {27'h000_0000, ctrl_q};
		else if (hit_ist)
			rd_val = {29'h0000_0000, int_status};
		else if (hit_ien)
			rd_val = {29'h0000_0000, int_enable};
		else if (hit_status)
			rd_val = {24'h00_0000, status_val};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata_q <= 32'h0000_0000;
		else if (setup_rd)
			prdata_q <= rd_val;
	end

	assign prdata = prdata_q;

	// ---------------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_sdf_set: assert property (ev.seq_done |=> sdf_q)
		else $error("done flag not set after sequence end");
	a_scan_again: assert property (
		run && cont && ev.seq_done && !start_wr && !ev.ctl_abort_wr
		|=> sdf_q && run)
		else $error("continuous mode did not keep running");
	a_sdf_fast_clr: assert property (
		ev.result_rd && seq_ctrl.fast_flag_clear && !ev.seq_done
		|=> !sdf_q)
		else $error("fast clear did not clear done flag");
	a_tof_edge: assert property (
		run && ev.trig_edge && seq_ctrl.ext_trig_en
		&& !seq_ctrl.trigger_level_select |=> tof_q)
		else $error("trigger overrun not flagged");
	a_tof_level: assert property (
		seq_ctrl.trigger_level_select && !tof_q
		|=> !tof_q)
		else $error("trigger overrun set in level mode");
	a_rof_set: assert property (
		ev.result_wr && ev.conv_flag_set |=> rof_q)
		else $error("result overrun not flagged");
	a_w1c_zero: assert property (
		wr_status && !pwdata[`ADS_BIT_SDF] && sdf_q && !start_wr
		&& !(seq_ctrl.fast_flag_clear && ev.result_rd) |=> sdf_q)
		else $error("writing zero cleared done flag");
	a_abort_clr: assert property (
		ev.ctl_abort_wr && !tof_set && !rof_set
		&& !start_wr && !trig_start
		|=> !tof_q && !rof_q && !run && seq_abort)
		else $error("abort did not clear overruns");
	a_start_clr: assert property (
		start_wr && !ev.seq_done && !tof_set && !rof_set
		|=> !sdf_q && !tof_q && !rof_q && run && seq_start)
		else $error("start write did not clear flags");
	a_idx_wr_keep: assert property (
		wr_status && !ev.conv_done && !ev.seq_done && !start_wr
		&& !ev.ctl_abort_wr && !trig_start
		|=> $stable(conversion_index))
		else $error("status write changed the index");
	a_bit6_zero: assert property (
		setup_rd && hit_status |=> prdata[`ADS_BIT_UNUSED] == 1'b0)
		else $error("unused status bit read as one");
	a_sdf_keep: assert property (
		sdf_q && ev.result_rd && !seq_ctrl.fast_flag_clear
		&& !wr_status && !start_wr |=> sdf_q)
		else $error("result read cleared done flag without fast clear");
	a_idx_read: assert property (
		setup_rd && hit_status
		|=> prdata[3:0] == $past(conversion_index))
		else $error("status read lost the index");
	a_trig_single: assert property (
		run && ev.seq_done && seq_ctrl.ext_trig_en && !start_wr
		|=> !run)
		else $error("triggered sequence did not stop");
	a_w1c_rof_zero: assert property (
		wr_status && !pwdata[`ADS_BIT_ROF] && rof_q && !start_wr
		&& !ev.ctl_abort_wr |=> rof_q)
		else $error("writing zero cleared result overrun");
	a_w1c_tof_zero: assert property (
		wr_status && !pwdata[`ADS_BIT_TOF] && tof_q && !start_wr
		&& !ev.ctl_abort_wr |=> tof_q)
		else $error("writing zero cleared trigger overrun");

	c_scan_run: cover property (run && cont && ev.seq_done);
	c_trig_ovr: cover property (tof_set ##[1:20] wr_status);
	c_fifo_wrap: cover property (
		seq_ctrl.fifo_mode && conversion_index == 4'hf && ev.conv_done);
	c_irq_up: cover property ($rose(irq));
	c_abort_run: cover property (run && ev.ctl_abort_wr);

endmodule // ads_seq_status

// ### rtl/ads_defines.svh
`ifndef ADS_DEFINES_SVH
`define ADS_DEFINES_SVH

// ---------------------------------------------------------------------------
// register map, byte addresses on the apb
// ---------------------------------------------------------------------------
`define ADS_ADDR_W          8
`define ADS_OFF_CTRL        8'h00
`define ADS_OFF_START       8'h04
`define ADS_OFF_INT_STATUS  8'h08
`define ADS_OFF_INT_CLEAR   8'h0c
`define ADS_OFF_INT_ENABLE  8'h10
`define ADS_IDX_STATUS      8'h06
`define ADS_OFF_STATUS      (`ADS_IDX_STATUS << 2)

// ---------------------------------------------------------------------------
// sequence_status fields
// ---------------------------------------------------------------------------
`define ADS_BIT_SDF         7
`define ADS_BIT_UNUSED      6
`define ADS_BIT_TOF         5
`define ADS_BIT_ROF         4
`define ADS_IDX_W           4

// ---------------------------------------------------------------------------
// control register fields and reset values
// ---------------------------------------------------------------------------
`define ADS_CTRL_FIFO       0
`define ADS_CTRL_FFC        1
`define ADS_CTRL_SCAN       2
`define ADS_CTRL_TLS        3
`define ADS_CTRL_ETE        4
`define ADS_CTRL_RST        5'h00

// ---------------------------------------------------------------------------
// interrupt bits: 0 sequence done, 1 trigger overrun, 2 result overrun
// ---------------------------------------------------------------------------
`define ADS_INT_W           3
`define ADS_INT_RST         3'h0

`endif

// ### rtl/ads_pkg.sv
package ads_pkg;

	typedef enum logic [1:0]
	{
		ADS_IDLE = 2'b01,
		ADS_RUN  = 2'b10
	} ads_run_e;

	// events from the sequencer, trigger and result logic (same clock)
	typedef struct packed
	{
		logic seq_done;
		logic conv_done;
		logic trig_edge;
		logic result_wr;
		logic conv_flag_set;
		logic result_rd;
		logic ctl_abort_wr;
	} ads_ev_s;

	typedef struct packed
	{
		logic ext_trig_en;
		logic trigger_level_select;
		logic scan_mode;
		logic fast_flag_clear;
		logic fifo_mode;
	} ads_ctrl_s;

	typedef logic [3:0] ads_idx_t;
	typedef logic [2:0] ads_int_t;

endpackage

// ### rtl/ads_conv_cnt.sv
`timescale 1ns/100ps
`include "ads_defines.svh"

module ads_conv_cnt
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             restart,
	input  wire logic             seq_bound,
	input  wire logic             conv_done,
	input  wire logic             fifo_mode,
	output ads_pkg::ads_idx_t     conversion_index
);
	import ads_pkg::*;

	ads_idx_t idx_q;
	ads_idx_t idx_d;
	wire      zero_now;

	// ---------------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------------
	// restart wins even in fifo mode; bounds only clear outside fifo mode
	assign zero_now = restart | (seq_bound & ~fifo_mode);
	// natural 4-bit overflow gives the wrap in fifo mode
	assign idx_d = zero_now ? '0 :
	               (conv_done ? idx_q + 4'h1 : idx_q);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			idx_q <= '0;
		else
			idx_q <= idx_d;
	end

	assign conversion_index = idx_q;

	// ---------------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_cnt_restart: assert property (restart |=> idx_q == 4'h0)
		else $error("counter not zero after restart");
	a_cnt_bound: assert property (
		seq_bound && !fifo_mode |=> idx_q == 4'h0)
		else $error("counter not zero at sequence bound");
	a_cnt_fifo_step: assert property (
		conv_done && fifo_mode && !restart
		|=> idx_q == 4'(($past(idx_q) + 4'h1)))
		else $error("fifo counter did not step or wrap");

endmodule // ads_conv_cnt

// ### rtl/ads_irq.sv
`timescale 1ns/100ps
`include "ads_defines.svh"

module ads_irq
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  ads_pkg::ads_int_t     set,
	input  wire logic             clr_wr,
	input  wire logic             en_wr,
	input  ads_pkg::ads_int_t     wdata,
	output ads_pkg::ads_int_t     int_status,
	output ads_pkg::ads_int_t     int_enable,
	output logic                  irq
);
	import ads_pkg::*;

	ads_int_t st_q;
	ads_int_t st_d;
	ads_int_t en_q;
	logic     irq_q;

	// ---------------------------------------------------------------------
	// sticky status, set beats a clear in the same cycle
	// ---------------------------------------------------------------------
	assign st_d = set | (st_q & ~(clr_wr ? wdata : '0));

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q  <= `ADS_INT_RST;
			en_q  <= `ADS_INT_RST;
			irq_q <= 1'b0;
		end
		else
		begin
			st_q  <= st_d;
			en_q  <= en_wr ? wdata : en_q;
			irq_q <= |(st_d & (en_wr ? wdata : en_q));
		end
	end

	assign int_status = st_q;
	assign int_enable = en_q;
	assign irq        = irq_q;

endmodule // ads_irq

// ### verification/ads_seq_status_tb.sv
`timescale 1ns/100ps
`include "ads_defines.svh"

module ads_seq_status_tb;
	import ads_pkg::*;

	// ---------------------------------------------------------------
	// stimulus, clock and timeout
	// ---------------------------------------------------------------
	localparam logic [6:0] EV_DONE = 7'h40;
	localparam logic [6:0] EV_CONV = 7'h20;
	localparam logic [6:0] EV_TRIG = 7'h10;
	localparam logic [6:0] EV_RWR  = 7'h08;
	localparam logic [6:0] EV_CFLG = 7'h04;
	localparam logic [6:0] EV_RRD  = 7'h02;
	localparam logic [6:0] EV_ABT  = 7'h01;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	ads_ev_s     ev = '0;
	ads_ctrl_s   seq_ctrl;
	ads_idx_t    conversion_index;
	logic        sequence_done_flag;
	logic        trigger_overrun_flag;
	logic        result_overrun_flag;
	logic        seq_running;
	logic        seq_start;
	logic        seq_abort;
	logic        irq;
	int          mismatches = 0;
	int          tests_run = 0;
	int          cycles = 0;

	always #2 clk = ~clk;

	ads_seq_status uut
	(
		.clk                  (clk),
		.rst                  (rst),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.paddr                (paddr),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.ev                   (ev),
		.seq_ctrl             (seq_ctrl),
		.conversion_index     (conversion_index),
		.sequence_done_flag   (sequence_done_flag),
		.trigger_overrun_flag (trigger_overrun_flag),
		.result_overrun_flag  (result_overrun_flag),
		.seq_running          (seq_running),
		.seq_start            (seq_start),
		.seq_abort            (seq_abort),
		.irq                  (irq)
	);

	// a hang ends the run after far more cycles than the tests need
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// bus, event and compare tasks
	// ---------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] d, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic        e;
		apb(1'b1, a, wd, d, e);
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: read %h, want %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		chk32(d, exp);
	endtask

	task automatic st(input logic [7:0] exp);
		rd(`ADS_OFF_STATUS, {24'h0, exp});
	endtask

	task automatic pulse(input logic [6:0] e, input int n);
		repeat (n)
		begin
			@(posedge clk);
			ev <= e;
			@(posedge clk);
			ev <= '0;
		end
		@(posedge clk);
		#1;
	endtask

	task automatic start(input logic [4:0] c);
		wr(`ADS_OFF_CTRL, {27'h0, c});
		wr(`ADS_OFF_START, 32'h0);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] d;
		logic        e;
		st(8'h00);
		wr(`ADS_OFF_CTRL, 32'h1f);
		rd(`ADS_OFF_CTRL, 32'h1f);
		chk32({27'h0, seq_ctrl}, 32'h1f);
		wr(`ADS_OFF_STATUS, 32'h4f);
		st(8'h00);
		apb(1'b0, 8'h40, 32'h0, d, e);
		chk1(e, 1'b1);
		chk32(d, 32'h0);
	endtask

	task automatic t_count();
		start(5'h00);
		pulse(EV_CONV, 3);
		wr(`ADS_OFF_STATUS, 32'hff);
		st(8'h03);
		pulse(EV_DONE, 1);
		st(8'h80);
		start(5'h01);
		st(8'h00);
		pulse(EV_CONV, 17);
		pulse(EV_DONE, 1);
		st(8'h81);
		pulse(EV_CONV, 2);
		pulse(EV_ABT, 1);
		chk32({28'h0, conversion_index}, 32'h0);
		wr(`ADS_OFF_START, 32'h0);
		#1;
		chk1(seq_start, 1'b1);
		chk1(seq_abort, 1'b0);
		st(8'h00);
	endtask

	task automatic t_overrun();
		start(5'h00);
		#1;
		chk1(seq_abort, 1'b1);
		pulse(EV_RWR | EV_CFLG, 1);
		wr(`ADS_OFF_STATUS, 32'h00);
		st(8'h10);
		wr(`ADS_OFF_STATUS, 32'h10);
		st(8'h00);
		pulse(EV_RWR, 1);
		chk1(result_overrun_flag, 1'b0);
		pulse(EV_RWR | EV_CFLG, 1);
		wr(`ADS_OFF_START, 32'h0);
		st(8'h00);
		pulse(EV_RWR | EV_CFLG, 1);
		pulse(EV_ABT, 1);
		chk1(result_overrun_flag, 1'b0);
	endtask

	task automatic t_trigger();
		start(5'h10);
		pulse(EV_DONE, 1);
		pulse(EV_TRIG, 1);
		chk1(seq_running, 1'b1);
		chk1(trigger_overrun_flag, 1'b0);
		pulse(EV_TRIG, 1);
		st(8'ha0);
		wr(`ADS_OFF_STATUS, 32'h20);
		st(8'h80);
		pulse(EV_TRIG, 1);
		pulse(EV_ABT, 1);
		st(8'h80);
		start(5'h18);
		pulse(EV_DONE, 1);
		pulse(EV_TRIG, 2);
		chk1(trigger_overrun_flag, 1'b0);
	endtask

	task automatic t_done();
		start(5'h02);
		pulse(EV_DONE, 1);
		pulse(EV_RRD, 1);
		st(8'h00);
		start(5'h00);
		pulse(EV_DONE, 1);
		pulse(EV_RRD, 1);
		st(8'h80);
		start(5'h04);
		pulse(EV_DONE, 1);
		wr(`ADS_OFF_STATUS, 32'h80);
		pulse(EV_DONE, 1);
		chk1(sequence_done_flag, 1'b1);
		chk1(seq_running, 1'b1);
	endtask

	task automatic t_irq();
		wr(`ADS_OFF_INT_CLEAR, 32'h7);
		wr(`ADS_OFF_INT_ENABLE, 32'h1);
		start(5'h00);
		pulse(EV_DONE, 1);
		chk1(irq, 1'b1);
		rd(`ADS_OFF_INT_STATUS, 32'h1);
		wr(`ADS_OFF_INT_ENABLE, 32'h0);
		pulse(7'h00, 1);
		chk1(irq, 1'b0);
		wr(`ADS_OFF_INT_ENABLE, 32'h7);
		pulse(EV_RWR | EV_CFLG, 1);
		rd(`ADS_OFF_INT_STATUS, 32'h5);
		wr(`ADS_OFF_INT_CLEAR, 32'h7);
		pulse(7'h00, 1);
		chk1(irq, 1'b0);
		rd(`ADS_OFF_INT_STATUS, 32'h0);
	endtask

	// ---------------------------------------------------------------
	// sequence and verdict
	// ---------------------------------------------------------------
	task automatic wrap_up();
		if (mismatches == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_count();
		t_overrun();
		t_trigger();
		t_done();
		t_irq();
		wrap_up();
	end

endmodule // ads_seq_status_tb
